// ---- design/rfsc_pkg.sv ----
/*
  Shared constants and types of the stream-mode codec.
  Assumes one 100 MHz clock and a carrier tick enable from the analog front end.
*/
`default_nettype none
package rfsc_pkg;
  // Register offsets
  localparam logic [5:0] ADDR_IO_CFG1 = 6'h00;
  localparam logic [5:0] ADDR_IO_CFG2 = 6'h01;
  localparam logic [5:0] ADDR_OP_CTRL = 6'h02;
  localparam logic [5:0] ADDR_MODE_SEL = 6'h03;
  localparam logic [5:0] ADDR_TYPEA = 6'h05;
  localparam logic [5:0] ADDR_STREAM = 6'h08;
  // Reset values
  localparam logic [7:0] IO_CFG1_RST = 8'h08;
  localparam logic [7:0] REG_RST = 8'h00;
  // Mode field of mode_select
  localparam int MODE_LSB = 3;
  localparam logic [4:0] MODE_SUBC = 5'h0e;
  localparam logic [4:0] MODE_BPSK = 5'h0f;
  // Fields of stream_options
  localparam int SCF_LSB = 5;
  localparam int SCP_LSB = 3;
  localparam int STX_LSB = 0;
  // Custom frame bits of typea_options
  localparam int TYPEA_CUST_LO = 6;
  localparam int TYPEA_CUST_HI = 7;
  // Timing: period bases and bit time in carrier cycles, rate code limits, quiet periods, last bit index
  localparam logic [9:0] SUBC_HALF_BASE = 10'h040;
  localparam logic [9:0] BPSK_HALF_BASE = 10'h010;
  localparam logic [1:0] SCP_MIN_SUBC = 2'h1;
  localparam logic [1:0] SCF_MAX_BPSK = 2'h2;
  localparam logic [7:0] TX_BIT_FC = 8'h80;
  localparam logic [3:0] QUIET_MAX = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rfsc_regif_type;

  typedef struct packed {
    logic set_default;
    logic tx_crc;
    logic tx_nocrc;
  } rfsc_cmd_type;

  typedef enum logic [1:0] {
    RX_OFF = 2'b00,
    RX_HUNT = 2'b01,
    RX_DATA = 2'b10
  } rfsc_rx_state_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b10
  } rfsc_tx_state_type;
endpackage
`default_nettype wire

// ---- design/rfsc_period_div.sv ----
/*
  Programmable period divider counting carrier ticks.
  Assumes len is held stable while the divider runs and is at least one.
*/
`default_nettype none
module rfsc_period_div #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic restart,
  input wire logic [W-1:0] len,
  output logic tick
);
  logic [W-1:0] cnt_q;

  // Count enabled ticks, wrap at len
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (restart)
      cnt_q <= '0;
    else if (en)
      cnt_q <= tick ? '0 : cnt_q + 1'b1;
  end

  assign tick = en && !restart && (cnt_q == len - 1'b1);
endmodule
`default_nettype wire

// ---- design/rfsc_bit_packer.sv ----
/*
  Packs received bits into bytes, first bit at bit 0.
  Assumes flush never coincides with bit_valid.
*/
`default_nettype none
module rfsc_bit_packer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic flush,
  output logic [7:0] byte_q,
  output logic valid_q,
  output logic [3:0] nbits_q
);
  import rfsc_pkg::*;
  logic [2:0] idx_q;
  logic [7:0] acc_q;

  // Place each bit at its index, emit full or flushed bytes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q <= '0;
      acc_q <= '0;
      byte_q <= '0;
      valid_q <= 1'b0;
      nbits_q <= '0;
    end
    else
    begin
      valid_q <= 1'b0;
      if (bit_valid)
      begin
        acc_q[idx_q] <= bit_in;
        idx_q <= idx_q + 1'b1;
        if (idx_q == LAST_BIT)
        begin
          byte_q <= {bit_in, acc_q[6:0]};
          valid_q <= 1'b1;
          nbits_q <= 4'h8;
          acc_q <= '0;
        end
      end
      else if (flush && idx_q != '0)
      begin
        byte_q <= acc_q;
        valid_q <= 1'b1;
        nbits_q <= {1'b0, idx_q};
        acc_q <= '0;
        idx_q <= '0;
      end
    end
  end

  chk_first_lsb: assert property (@(posedge clk) disable iff (!rst_n)
    bit_valid && idx_q == '0 |=> acc_q[0] == $past(bit_in) || valid_q)
    else $error("first bit not at lsb");
endmodule
`default_nettype wire

// ---- design/rfsc_stream_codec.sv ----
/*
  Stream-mode codec: on/off and phase receive framing, on/off keyed transmit,
  and the registers that configure it, reached by a plain register port.
  Assumes rx_sub and fc_tick are synchronous to mclk; fc_tick pulses once per
  carrier cycle; the FIFOs, command decoder and analog chain sit outside.
*/
`default_nettype none
module rfsc_stream_codec #(
  parameter int RPT_W = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fc_tick,
  input wire logic rx_sub,
  input wire logic rx_on,
  input wire rfsc_pkg::rfsc_regif_type reg_bus,
  output logic [7:0] reg_rdata_q,
  input wire rfsc_pkg::rfsc_cmd_type cmd,
  input wire logic [15:0] tx_nbits,
  input wire logic [7:0] tx_fifo_data,
  input wire logic tx_fifo_valid,
  output logic tx_fifo_pop_q,
  output logic [7:0] rx_fifo_data_q,
  output logic rx_fifo_wr_q,
  output logic [3:0] rx_fifo_nbits_q,
  output logic rx_start_q,
  output logic rx_end_q,
  output logic tx_mod_q,
  output logic tx_busy_q,
  output logic tx_crc_q,
  output logic typea_custom_q
);
  import rfsc_pkg::*;

  if (RPT_W < 10)
    $error("RPT_W too small for longest reporting period");

  logic rst_meta_q;
  logic rst_sync_n;
  logic [7:0] io_cfg1_q, io_cfg2_q, op_ctrl_q;
  logic [7:0] mode_sel_q, typea_q, stream_q;
  logic subc_mode, bpsk_mode, stream_mode;
  logic [1:0] scf, scp, scf_eff, scp_eff;
  logic [2:0] stx;
  logic [RPT_W-1:0] rpt_len;
  logic [7:0] bit_len;
  logic rpt_tick, bit_tick;
  logic rx_run, sub_prev_q, rise, present_q, present_now, ref_q;
  rfsc_rx_state_type rx_state_q, rx_state_d;
  logic [3:0] quiet_q, quiet_d;
  logic pk_valid, pk_bit, pk_flush, start_d, end_d;
  rfsc_tx_state_type tx_state_q;
  logic [15:0] tx_left_q;
  logic [2:0] tx_idx_q;
  logic [7:0] tx_byte_q;
  logic tx_go;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // Hardware configuration registers, reset only at power-up
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      io_cfg1_q <= IO_CFG1_RST;
      io_cfg2_q <= REG_RST;
      op_ctrl_q <= REG_RST;
    end
    else if (reg_bus.wr)
    begin
      if (reg_bus.addr == ADDR_IO_CFG1)
        io_cfg1_q <= reg_bus.wdata;
      if (reg_bus.addr == ADDR_IO_CFG2)
        io_cfg2_q <= reg_bus.wdata;
      if (reg_bus.addr == ADDR_OP_CTRL)
        op_ctrl_q <= reg_bus.wdata;
    end
  end

  // Mode registers, also restored by set default
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      mode_sel_q <= REG_RST;
      typea_q <= REG_RST;
      stream_q <= REG_RST;
    end
    else if (cmd.set_default)
    begin
      mode_sel_q <= REG_RST;
      typea_q <= REG_RST;
      stream_q <= REG_RST;
    end
    else if (reg_bus.wr)
    begin
      if (reg_bus.addr == ADDR_MODE_SEL)
        mode_sel_q <= reg_bus.wdata;
      if (reg_bus.addr == ADDR_TYPEA)
        typea_q <= reg_bus.wdata;
      if (reg_bus.addr == ADDR_STREAM)
        stream_q <= reg_bus.wdata;
    end
  end

  // Registered read port, unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reg_rdata_q <= '0;
    else if (reg_bus.rd)
    begin
      case (reg_bus.addr)
        ADDR_IO_CFG1: reg_rdata_q <= io_cfg1_q;
        ADDR_IO_CFG2: reg_rdata_q <= io_cfg2_q;
        ADDR_OP_CTRL: reg_rdata_q <= op_ctrl_q;
        ADDR_MODE_SEL: reg_rdata_q <= mode_sel_q;
        ADDR_TYPEA: reg_rdata_q <= typea_q;
        ADDR_STREAM: reg_rdata_q <= stream_q;
        default: reg_rdata_q <= '0;
      endcase
    end
  end

  // Custom Type A frame enable
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      typea_custom_q <= 1'b0;
    else
      typea_custom_q <= typea_q[TYPEA_CUST_HI] && typea_q[TYPEA_CUST_LO];
  end

  // Mode decode and period lengths; analog setup is left to the host
  assign subc_mode = mode_sel_q[7:MODE_LSB] == MODE_SUBC;
  assign bpsk_mode = mode_sel_q[7:MODE_LSB] == MODE_BPSK;
  assign stream_mode = subc_mode || bpsk_mode;
  assign scf = stream_q[SCF_LSB+1:SCF_LSB];
  assign scp = stream_q[SCP_LSB+1:SCP_LSB];
  assign stx = stream_q[STX_LSB+2:STX_LSB];
  assign scf_eff = (bpsk_mode && scf > SCF_MAX_BPSK) ? SCF_MAX_BPSK : scf;
  assign scp_eff = (subc_mode && scp < SCP_MIN_SUBC) ? SCP_MIN_SUBC : scp;
  assign rpt_len = RPT_W'(((bpsk_mode ? BPSK_HALF_BASE : SUBC_HALF_BASE) >> scf_eff) << scp_eff);
  assign bit_len = (TX_BIT_FC >> stx) | {7'h00, stx == LAST_BIT};

  rfsc_period_div #(.W(RPT_W)) u_rpt_div (
    .clk(mclk),
    .rst_n(rst_sync_n),
    .en(fc_tick),
    .restart(!rx_run),
    .len(rpt_len),
    .tick(rpt_tick)
  );

  // Sub-carrier presence over one reporting period
  assign rx_run = rx_on && stream_mode;
  assign rise = fc_tick && rx_sub && !sub_prev_q;
  assign present_now = present_q || rise;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sub_prev_q <= 1'b0;
      present_q <= 1'b0;
    end
    else
    begin
      if (fc_tick)
        sub_prev_q <= rx_sub;
      present_q <= (rpt_tick || !rx_run) ? 1'b0 : present_now;
    end
  end

  // Receive framing decisions per reporting period
  always_comb
  begin
    rx_state_d = rx_state_q;
    quiet_d = quiet_q;
    pk_valid = 1'b0;
    pk_bit = 1'b0;
    pk_flush = 1'b0;
    start_d = 1'b0;
    end_d = 1'b0;
    case (rx_state_q)
      RX_OFF:
        if (rx_run)
          rx_state_d = RX_HUNT;
      RX_HUNT:
        if (rpt_tick && present_now)
        begin
          start_d = 1'b1;
          pk_valid = 1'b1;
          pk_bit = subc_mode;
          quiet_d = '0;
          rx_state_d = RX_DATA;
        end
      RX_DATA:
        if (rpt_tick)
        begin
          if (subc_mode)
          begin
            quiet_d = present_now ? '0 : quiet_q + 1'b1;
            if (!present_now && quiet_q == QUIET_MAX)
            begin
              end_d = 1'b1;
              pk_flush = 1'b1;
              rx_state_d = RX_HUNT;
            end
            else
            begin
              pk_valid = 1'b1;
              pk_bit = present_now;
            end
          end
          else if (present_now)
          begin
            pk_valid = 1'b1;
            pk_bit = rx_sub ^ ref_q;
          end
          else
          begin
            end_d = 1'b1;
            pk_flush = 1'b1;
            rx_state_d = RX_HUNT;
          end
        end
      default:
        rx_state_d = RX_OFF;
    endcase
    if (!rx_run)
    begin
      rx_state_d = RX_OFF;
      pk_valid = 1'b0;
      pk_flush = rx_state_q == RX_DATA;
    end
  end

  // Receive state, phase reference and event pulses
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_state_q <= RX_OFF;
      quiet_q <= '0;
      ref_q <= 1'b0;
      rx_start_q <= 1'b0;
      rx_end_q <= 1'b0;
    end
    else
    begin
      rx_state_q <= rx_state_d;
      quiet_q <= quiet_d;
      rx_start_q <= start_d;
      rx_end_q <= end_d;
      if (start_d)
        ref_q <= rx_sub;
    end
  end

  rfsc_bit_packer u_packer (
    .clk(mclk),
    .rst_n(rst_sync_n),
    .bit_valid(pk_valid),
    .bit_in(pk_bit),
    .flush(pk_flush),
    .byte_q(rx_fifo_data_q),
    .valid_q(rx_fifo_wr_q),
    .nbits_q(rx_fifo_nbits_q)
  );

  rfsc_period_div #(.W(8)) u_bit_div (
    .clk(mclk),
    .rst_n(rst_sync_n),
    .en(fc_tick && tx_state_q == TX_SEND),
    .restart(tx_state_q != TX_SEND),
    .len(bit_len),
    .tick(bit_tick)
  );

  // Transmit sequencing: fetch byte, send bits LSB first
  assign tx_go = (cmd.tx_crc || cmd.tx_nocrc) && stream_mode && tx_nbits != '0;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_state_q <= TX_IDLE;
      tx_left_q <= '0;
      tx_idx_q <= '0;
      tx_byte_q <= '0;
      tx_fifo_pop_q <= 1'b0;
      tx_crc_q <= 1'b0;
    end
    else
    begin
      tx_fifo_pop_q <= 1'b0;
      case (tx_state_q)
        TX_IDLE:
          if (tx_go)
          begin
            tx_left_q <= tx_nbits;
            tx_idx_q <= '0;
            tx_crc_q <= cmd.tx_crc;
            tx_state_q <= TX_LOAD;
          end
        TX_LOAD:
          if (tx_fifo_valid && !tx_fifo_pop_q)
          begin
            tx_byte_q <= tx_fifo_data;
            tx_fifo_pop_q <= 1'b1;
            tx_state_q <= TX_SEND;
          end
        TX_SEND:
          if (bit_tick)
          begin
            if (tx_left_q == 16'h0001)
              tx_state_q <= TX_IDLE;
            else
            begin
              tx_left_q <= tx_left_q - 1'b1;
              tx_idx_q <= tx_idx_q + 1'b1;
              if (tx_idx_q == LAST_BIT)
                tx_state_q <= TX_LOAD;
            end
          end
        default:
          tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Modulator drive, held across byte fetches
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_mod_q <= 1'b0;
      tx_busy_q <= 1'b0;
    end
    else
    begin
      tx_busy_q <= tx_state_q != TX_IDLE;
      if (tx_state_q == TX_SEND)
        tx_mod_q <= tx_byte_q[tx_idx_q];
      else if (tx_state_q == TX_IDLE)
        tx_mod_q <= 1'b0;
    end
  end

  chk_subc_range: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    subc_mode |-> rpt_len >= 10'd16 && rpt_len <= 10'd512)
    else $error("on/off reporting period out of range");
  chk_bpsk_range: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    bpsk_mode |-> rpt_len >= 10'd4 && rpt_len <= 10'd128)
    else $error("phase reporting period out of range");
  chk_rate_codes: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (subc_mode && scf == 2'h1 && scp == 2'h2 |-> rpt_len == 10'd128) and
    (bpsk_mode && scf == 2'h1 && scp == 2'h1 |-> rpt_len == 10'd16))
    else $error("rate code decode wrong");
  chk_start_write: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rx_run && rx_state_q == RX_HUNT && rpt_tick && present_now |=> rx_start_q && rx_state_q == RX_DATA)
    else $error("start not raised on first sub-carrier period");
  chk_subc_quiet_end: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rx_end_q && subc_mode && $past(rx_run) |-> $past(quiet_q) == QUIET_MAX)
    else $error("on/off end without nine quiet periods");
  chk_bpsk_end: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rx_run && bpsk_mode && rx_state_q == RX_DATA && rpt_tick && !present_now |=> rx_end_q)
    else $error("phase end missed");
  chk_bpsk_phase: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pk_valid && bpsk_mode && rx_state_q == RX_DATA |-> pk_bit == (rx_sub ^ ref_q))
    else $error("phase bit wrong");
  chk_tx_bit_time: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    stx == 3'h0 |-> bit_len == 8'd128)
    else $error("bit time code 000b not 128");
  chk_tx_mod_bit: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    tx_state_q == TX_SEND ##1 tx_state_q == TX_SEND |-> tx_mod_q == $past(tx_byte_q[tx_idx_q]))
    else $error("modulator does not follow bit");
  chk_tx_stop: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    tx_state_q == TX_SEND && bit_tick && tx_left_q == 16'h0001 |=> ##1 !tx_mod_q && !tx_busy_q)
    else $error("transmit did not stop");
  chk_set_default: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    cmd.set_default && !(reg_bus.wr && reg_bus.addr == ADDR_IO_CFG1) |=>
    mode_sel_q == REG_RST && io_cfg1_q == $past(io_cfg1_q))
    else $error("set default wrong");
  chk_typea_custom: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    typea_q[7:6] == 2'b11 |=> typea_custom_q || $past(typea_q[7:6]) != 2'b11)
    else $error("custom frames not enabled");

  cov_subc_frame: cover property (@(posedge mclk) disable iff (!rst_sync_n) subc_mode && rx_end_q);
  cov_bpsk_frame: cover property (@(posedge mclk) disable iff (!rst_sync_n) bpsk_mode && rx_end_q);
  cov_rx_byte: cover property (@(posedge mclk) disable iff (!rst_sync_n) rx_fifo_wr_q);
  cov_tx_done: cover property (@(posedge mclk) disable iff (!rst_sync_n) $fell(tx_busy_q));
endmodule
`default_nettype wire

// ---- verification/rfsc_tag_model.sv ----
/*
  Tag-side model: makes the carrier tick and a sub-carrier stream.
  Assumes go starts a frame at the same edge that enables the receiver.
*/
`default_nettype none
module rfsc_tag_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic phase,
  input wire logic [7:0] pat,
  output logic fc_tick,
  output logic rx_sub
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] n_q;
  logic [15:0] np2;
  logic [15:0] np8;
  int idx;
  logic bitv;
  // Carrier tick every second clock, frame tick count
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fc_tick <= 1'b0;
      n_q <= 16'h0000;
    end
    else
    begin
      fc_tick <= ~fc_tick;
      n_q <= !go ? 16'h0000 : n_q + 16'(fc_tick);
    end
  end
  // Bits sit mid-period in phase mode so period-end samples stay clear of edges
  always_comb
  begin
    np2 = n_q + 16'h0002;
    np8 = n_q + 16'h0008;
    idx = phase ? (int'(n_q) + 8) / 16 - 1 : int'(n_q) / 128;
    bitv = (idx >= 0 && idx < 8) ? pat[idx[2:0]] : 1'b0;
    if (!go || idx < 0 || n_q >= (phase ? 16'h0084 : 16'h0400))
      rx_sub = 1'b0;
    else if (phase)
      rx_sub = bitv ^ ~np2[2];
    else
      rx_sub = bitv & np8[4];
  end
endmodule
`default_nettype wire

// ---- verification/rfsc_stream_codec_bench.sv ----
/*
  Self-checking bench of the stream codec: registers, both receive variants,
  transmit. Assumes the tag model supplies the carrier tick and sub-carrier.
*/
`default_nettype none
module rfsc_stream_codec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rfsc_pkg::*;
  logic mclk, rst_n, rx_on, go, phase, fc_tick, rx_sub;
  logic [7:0] pat;
  rfsc_regif_type reg_bus;
  rfsc_cmd_type cmd;
  logic [15:0] tx_nbits;
  logic [7:0] reg_rdata_q, rx_fifo_data_q;
  logic [3:0] rx_fifo_nbits_q;
  logic tx_fifo_pop_q, rx_fifo_wr_q, rx_start_q, rx_end_q, tx_mod_q, tx_busy_q, tx_crc_q, typea_custom_q;
  logic [7:0] txb[2] = '{8'ha5, 8'h02};
  int pidx, mismatches, checks, starts, ends;
  logic [11:0] rxq[$];

  rfsc_stream_codec #(.RPT_W(10)) dut_u (.mclk(mclk), .rst_n(rst_n), .fc_tick(fc_tick), .rx_sub(rx_sub),
    .rx_on(rx_on), .reg_bus(reg_bus), .reg_rdata_q(reg_rdata_q), .cmd(cmd), .tx_nbits(tx_nbits),
    .tx_fifo_data(txb[pidx[0]]), .tx_fifo_valid(pidx < 2), .tx_fifo_pop_q(tx_fifo_pop_q),
    .rx_fifo_data_q(rx_fifo_data_q), .rx_fifo_wr_q(rx_fifo_wr_q), .rx_fifo_nbits_q(rx_fifo_nbits_q),
    .rx_start_q(rx_start_q), .rx_end_q(rx_end_q), .tx_mod_q(tx_mod_q), .tx_busy_q(tx_busy_q),
    .tx_crc_q(tx_crc_q), .typea_custom_q(typea_custom_q));
  rfsc_tag_model tag_u (.mclk(mclk), .rst_n(rst_n), .go(go), .phase(phase), .pat(pat),
    .fc_tick(fc_tick), .rx_sub(rx_sub));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Transmit FIFO head advances on pop; receive events are collected
  always @(posedge mclk)
  begin
    if (tx_fifo_pop_q) pidx <= pidx + 1;
    if (rx_fifo_wr_q) rxq.push_back({rx_fifo_nbits_q, rx_fifo_data_q});
    if (rx_start_q) starts++;
    if (rx_end_q) ends++;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk) reg_bus <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) reg_bus <= '0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk) reg_bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) reg_bus <= '0;
    #1 chk(12'(reg_rdata_q), 12'(e));
  endtask
  task automatic pulse(input rfsc_cmd_type c);
    @(posedge mclk) cmd <= c;
    @(posedge mclk) cmd <= '0;
  endtask
  task automatic test_regs;
    rdc(ADDR_IO_CFG1, IO_CFG1_RST);
    rdc(ADDR_STREAM, REG_RST);
    wr(ADDR_IO_CFG1, 8'h5a);
    wr(ADDR_TYPEA, 8'hc0);
    wr(ADDR_STREAM, 8'h30);
    rdc(ADDR_STREAM, 8'h30);
    chk(12'(typea_custom_q), 12'h001);
    pulse('{1'b1, 1'b0, 1'b0});
    rdc(ADDR_TYPEA, REG_RST);
    rdc(ADDR_STREAM, REG_RST);
    rdc(ADDR_IO_CFG1, 8'h5a);
    rdc(6'h3f, 8'h00);
    chk(12'(typea_custom_q), 12'h000);
  endtask
  // Starts a tag frame with the receiver on and waits for end of receive
  task automatic rx_go(input logic ph, input logic [7:0] p);
    rxq.delete();
    starts = 0;
    ends = 0;
    @(posedge mclk)
    begin
      rx_on <= 1'b1;
      go <= 1'b1;
      phase <= ph;
      pat <= p;
    end
    for (int i = 0; i < 6000 && ends == 0; i++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    rx_on <= 1'b0;
    go <= 1'b0;
    chk(12'(starts), 12'h001);
    chk(12'(ends), 12'h001);
  endtask
  task automatic rx_onoff;
    wr(ADDR_MODE_SEL, {MODE_SUBC, 3'h0});
    wr(ADDR_STREAM, 8'h30);
    rx_go(1'b0, 8'hcd);
    chk(12'(rxq.size()), 12'h002);
    chk(rxq[0], 12'h8cd);
    chk(rxq[1], 12'h800);
  endtask
  task automatic rx_phase;
    wr(ADDR_MODE_SEL, {MODE_BPSK, 3'h0});
    wr(ADDR_STREAM, 8'h28);
    rx_go(1'b1, 8'h2c);
    chk(12'(rxq.size()), 12'h001);
    chk(rxq[0], 12'h82c);
  endtask
  // Sends ten bits and samples the modulator mid-bit
  task automatic tx_run(input logic [2:0] stx, input logic crc);
    int bl;
    logic [9:0] exp;
    bl = 128 >> stx;
    exp = 10'h2a5;
    wr(ADDR_MODE_SEL, {MODE_SUBC, 3'h0});
    wr(ADDR_STREAM, {5'h00, stx});
    @(posedge mclk)
    begin
      pidx <= 0;
      tx_nbits <= 16'h000a;
    end
    pulse('{1'b0, crc, !crc});
    for (int i = 0; i < 100 && tx_mod_q !== 1'b1; i++) @(posedge mclk);
    for (int k = 0; k < 10; k++)
    begin
      repeat (bl / 2) @(posedge mclk iff fc_tick);
      chk(12'(tx_mod_q), 12'(exp[k]));
      chk(12'(tx_busy_q), 12'h001);
      repeat (bl - bl / 2) @(posedge mclk iff fc_tick);
    end
    for (int i = 0; i < 100 && tx_busy_q !== 1'b0; i++) @(posedge mclk);
    chk(12'(tx_busy_q), 12'h000);
    chk(12'(tx_mod_q), 12'h000);
    chk(12'(tx_crc_q), 12'(crc));
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    end_of_test;
  end
  initial
  begin
    rst_n = 1'b0;
    {rx_on, go, phase, pat, tx_nbits} = '0;
    reg_bus = '0;
    cmd = '0;
    pidx = 2;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    test_regs();
    rx_onoff();
    rx_phase();
    tx_run(3'h0, 1'b0);
    tx_run(3'h1, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
